// ---- verilog/pbdt_data_tenure.sv ----
// data tenure engine: grant qualification, reorder, beats, parity
`timescale 1ns/10ps
module pbdt_data_tenure
	import pbdt_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic reset_i,
	input wire logic data_grant_in_i,
	input wire logic write_reorder_permit_i,
	input wire logic beat_acknowledge_i,
	input wire logic transfer_error_ack_i,
	input wire logic address_retry_i,
	input wire logic transfer_start_i,
	input wire logic address_ack_i,
	input wire logic [PBDT_DATA_W-1:0] data_bus_i,
	input wire logic [PBDT_LANES-1:0] lane_parity_i,
	input wire logic req_valid_i,
	input wire logic req_write_i,
	input wire logic req_burst_i,
	input wire logic [PBDT_DATA_W-1:0] wdata_i,
	input wire logic parity_gen_en_i,
	input wire logic parity_chk_en_i,
	output logic [PBDT_DATA_W-1:0] data_bus_o,
	output logic [PBDT_LANES-1:0] lane_parity_o,
	output logic data_oe_n_o,
	output logic data_busy_out_n_o,
	output logic data_busy_oe_n_o,
	output logic [PBDT_DATA_W-1:0] rdata_o,
	output logic rdata_valid_o,
	output logic wdata_req_o,
	output logic tenure_done_o,
	output logic tenure_err_o,
	output logic checkstop_o
);
	// timing through the block, in bus cycles:
	// every pin passes two flip-flops, so the logic acts two edges after a pin moves
	// data and parity pins get the same two stages, keeping read beats on their ack
	// a transfer start with a user request queues one entry, oldest in slot 0
	// the queue has no gaps unless a start lands in the cycle a retry drops the newest entry; gap free, the newest entry sits below the first free slot
	// the retry window opens on the synced address ack and lasts two cycles
	// a retry seen inside the window removes the newest entry again
	// grant counts only with a queued entry, a closed clean window and an idle side
	// the reorder permit and the entry choice are taken in the qualified grant cycle
	// busy and the first write beat appear on the edge after the qualified grant
	// a write beat stays on the lines until its acknowledge has been seen
	// the next write beat is loaded on the edge after that acknowledge
	// each loaded write beat pulses the user request so the next word can follow
	// a read beat is handed over with a one cycle valid pulse, in beat order
	// the edge after the final acknowledge drives busy high and floats the data
	// one more cycle later the busy line floats as well, so busy is never cut
	// the release cycle also keeps a new tenure from streaming straight on
	// an error acknowledge ends the tenure at once and beats any beat acknowledge
	// a parity error on an acknowledged read beat sets checkstop until reset
	// hazard: the far side sees all answers two cycles late and must pace for it
	// limitation: a full queue of four ignores further transfer starts

	pbdt_state_s_t s_ff;
	pbdt_state_s_t nxt_s;

	// synchronised pin levels, read from the second stage only
	// the first stage may be metastable, so nothing else looks at it
	logic ack; // beat acknowledge
	logic transfer_error_ack; // transfer error acknowledge
	logic dbg; // data grant
	logic perm; // write reorder permit
	logic ts; // transfer start
	logic address_ack; // address acknowledge
	logic rty; // address retry
	assign ack = s_ff.sync_ack[1];
	assign transfer_error_ack = s_ff.sync_tea[1];
	assign dbg = s_ff.sync_dbg[1];
	assign perm = s_ff.sync_perm[1];
	assign ts = s_ff.sync_ts[1];
	assign address_ack = s_ff.sync_address_ack[1];
	assign rty = s_ff.sync_rty[1];

	// data bus pins sampled twice so reads line up with acknowledge
	// ack and data pass the same depth, so the beat seen is the beat acknowledged
	logic [PBDT_DATA_W-1:0] din_a_ff; // first stage, read by nothing else
	logic [PBDT_DATA_W-1:0] din_b_ff;
	logic [PBDT_LANES-1:0] pin_a_ff;
	logic [PBDT_LANES-1:0] pin_b_ff;
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			din_a_ff <= PBDT_DATA_RST;
			din_b_ff <= PBDT_DATA_RST;
			pin_a_ff <= PBDT_PAR_RST;
			pin_b_ff <= PBDT_PAR_RST;
		end else begin
			din_a_ff <= data_bus_i;
			din_b_ff <= din_a_ff;
			pin_a_ff <= lane_parity_i;
			pin_b_ff <= pin_a_ff;
		end
	end

	// lane parity of a 64-bit word, lane 0 in the top byte of the high half
	function automatic logic [PBDT_LANES-1:0] lane_par(input logic [PBDT_DATA_W-1:0] d);
		logic [PBDT_LANES-1:0] p;
		p = '0;
		for (int i = 0; i < PBDT_LANES; i++) begin
			p[PBDT_LANES-1-i] = pbdt_odd_par(d[PBDT_DATA_W-1-8*i -: 8]);
		end
		return p;
	endfunction : lane_par

	// lane parity for a write beat, held low when generation is off
	function automatic logic [PBDT_LANES-1:0] beat_par(input logic en,
		input logic [PBDT_DATA_W-1:0] d);
		return en ? lane_par(d) : PBDT_PAR_RST;
	endfunction : beat_par

	// index of the last beat for a tenure of this kind
	function automatic logic [1:0] last_beat(input logic burst);
		return burst ? PBDT_BURST_LAST : PBDT_SINGLE_LAST;
	endfunction : last_beat

	// first free slot; with no gaps it follows the newest entry
	function automatic logic [1:0] free_slot(input logic [PBDT_Q_DEPTH-1:0] v);
		logic [1:0] f;
		f = 2'h0;
		for (int i = PBDT_Q_DEPTH-1; i >= 0; i--) begin
			if (!v[i]) begin
				f = 2'(i);
			end
		end
		return f;
	endfunction : free_slot

	// highest valid slot, which holds the newest entry
	function automatic logic [1:0] newest_slot(input logic [PBDT_Q_DEPTH-1:0] v);
		logic [1:0] n;
		n = 2'h0;
		for (int i = 0; i < PBDT_Q_DEPTH; i++) begin
			if (v[i]) begin
				n = 2'(i);
			end
		end
		return n;
	endfunction : newest_slot

	logic qgrant;
	logic pick_write;
	logic [1:0] sel;
	logic have_write;
	logic [1:0] first_write;
	logic final_beat;
	logic [PBDT_LANES-1:0] par_bad;
	logic win_clean;
	logic side_idle;

	// queue search and grant qualification
	always_comb begin
		have_write = 1'b0;
		first_write = 2'h0;
		// the oldest write is the lowest valid slot holding a write
		for (int i = PBDT_Q_DEPTH-1; i >= 0; i--) begin
			if (s_ff.qv[i] && s_ff.q[i].write) begin
				have_write = 1'b1;
				first_write = 2'(i);
			end
		end
		// address tenure acknowledged and its retry window over and clean
		win_clean = !s_ff.wait_ack && !s_ff.win_retried && (s_ff.win_cnt == 2'h0);
		// no tenure running and none released in the last cycle
		side_idle = s_ff.st == PBDT_IDLE;
		// grant only counts once an address tenure queued data and its window is clean
		qgrant = dbg && s_ff.qv[0] && win_clean && side_idle;
		// permit sampled only here; without a write it is ignored
		pick_write = perm && have_write;
		sel = pick_write ? first_write : 2'h0;
		final_beat = s_ff.beat == last_beat(s_ff.cur_burst);
		par_bad = ~(lane_par(din_b_ff) ^ ~pin_b_ff);
	end

	// next state
	always_comb begin
		nxt_s = s_ff;
		nxt_s.sync_ack = {s_ff.sync_ack[0], beat_acknowledge_i};
		nxt_s.sync_tea = {s_ff.sync_tea[0], transfer_error_ack_i};
		nxt_s.sync_dbg = {s_ff.sync_dbg[0], data_grant_in_i};
		nxt_s.sync_perm = {s_ff.sync_perm[0], write_reorder_permit_i};
		nxt_s.sync_ts = {s_ff.sync_ts[0], transfer_start_i};
		nxt_s.sync_address_ack = {s_ff.sync_address_ack[0], address_ack_i};
		nxt_s.sync_rty = {s_ff.sync_rty[0], address_retry_i};
		// pulses last one cycle unless set again below
		nxt_s.rvalid = 1'b0;
		nxt_s.wreq = 1'b0;
		nxt_s.done = 1'b0;
		nxt_s.err = 1'b0;

		// address tenure tracking: start queues entry, retry window follows ack
		if (ts && req_valid_i && !s_ff.qv[PBDT_Q_DEPTH-1]) begin
			nxt_s.wait_ack = 1'b1;
		end
		// the window counts down from the synced address ack
		if (s_ff.wait_ack && address_ack) begin
			nxt_s.wait_ack = 1'b0;
			nxt_s.win_cnt = PBDT_RETRY_WIN;
			nxt_s.win_retried = rty;
		end else if (s_ff.win_cnt != 2'h0) begin
			nxt_s.win_cnt = s_ff.win_cnt - 2'h1;
			if (rty) begin
				nxt_s.win_retried = 1'b1;
			end
		end else begin
			// the retried flag clears once the window is over
			nxt_s.win_retried = 1'b0;
		end

		// enqueue on transfer start into the slot after the newest entry
		// a full queue ignores the start; the far side must not exceed four
		if (ts && req_valid_i && !s_ff.qv[PBDT_Q_DEPTH-1]) begin
			nxt_s.qv[free_slot(s_ff.qv)] = 1'b1;
			nxt_s.q[free_slot(s_ff.qv)].write = req_write_i;
			nxt_s.q[free_slot(s_ff.qv)].burst = req_burst_i;
		end

		// a retry seen in the window drops the newest entry again
		if (s_ff.win_cnt == 2'h1 && (s_ff.win_retried || rty)) begin
			nxt_s.qv[newest_slot(s_ff.qv)] = 1'b0;
		end

		unique case (s_ff.st)
			PBDT_IDLE: begin
				if (qgrant) begin
					// remove chosen entry and close the gap
					// shifting the next copy keeps a start queued in this same cycle
					nxt_s.cur_write = s_ff.q[sel].write;
					nxt_s.cur_burst = s_ff.q[sel].burst;
					for (int i = 0; i < PBDT_Q_DEPTH-1; i++) begin
						if (i >= int'(sel)) begin
							nxt_s.q[i] = nxt_s.q[i+1];
							nxt_s.qv[i] = nxt_s.qv[i+1];
						end
					end
					nxt_s.q[PBDT_Q_DEPTH-1] = '0;
					nxt_s.qv[PBDT_Q_DEPTH-1] = 1'b0;
					nxt_s.beat = 2'h0;
					nxt_s.busy_n = 1'b0;
					nxt_s.busy_oe_n = 1'b0;
					nxt_s.st = PBDT_XFER;
					if (s_ff.q[sel].write) begin
						nxt_s.dout = wdata_i;
						nxt_s.pout = beat_par(parity_gen_en_i, wdata_i);
						nxt_s.doe_n = 1'b0;
						nxt_s.wreq = 1'b1;
					end
				end
			end
			PBDT_XFER: begin
				if (transfer_error_ack) begin
					// error overrides acknowledge and ends the tenure
					nxt_s.busy_n = 1'b1;
					nxt_s.doe_n = 1'b1;
					nxt_s.err = 1'b1;
					nxt_s.st = PBDT_REL;
				// acknowledge ends one beat; read data comes from the matching stage
				end else if (ack) begin
					if (!s_ff.cur_write) begin
						nxt_s.rdata = din_b_ff;
						nxt_s.rvalid = 1'b1;
						if (parity_chk_en_i && (par_bad != '0)) begin
							nxt_s.checkstop = 1'b1;
						end
					end
					// last beat: busy goes high now and floats one cycle later
					if (final_beat) begin
						nxt_s.busy_n = 1'b1;
						nxt_s.doe_n = 1'b1;
						nxt_s.done = 1'b1;
						nxt_s.st = PBDT_REL;
					end else begin
						nxt_s.beat = s_ff.beat + 2'h1;
						if (s_ff.cur_write) begin
							nxt_s.dout = wdata_i;
							nxt_s.pout = beat_par(parity_gen_en_i, wdata_i);
							nxt_s.wreq = 1'b1;
						end
					end
				end
				// no acknowledge: outputs hold
			end
			PBDT_REL: begin
				// negated for one full cycle, then released
				nxt_s.busy_oe_n = 1'b1;
				nxt_s.st = PBDT_IDLE;
			end
			default: nxt_s.st = PBDT_IDLE;
		endcase

		// a retry inside the window aborts the running tenure, whichever transaction it belongs to
		// the grant waits for a closed window, so this only guards a late retry
		if (s_ff.st == PBDT_XFER && s_ff.win_cnt != 2'h0 && rty) begin
			nxt_s.busy_n = 1'b1;
			nxt_s.doe_n = 1'b1;
			nxt_s.st = PBDT_REL;
		end
	end

	// state register
	// the reset branch loads constants only
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			s_ff <= '{
				st: PBDT_IDLE,
				doe_n: 1'b1, // data lines float
				busy_n: 1'b1,
				busy_oe_n: 1'b1, // busy line floats
				dout: PBDT_DATA_RST,
				rdata: PBDT_DATA_RST,
				default: '0
			};
		end else begin
			s_ff <= nxt_s;
		end
	end

	// pin outputs straight from the state register
	assign data_bus_o = s_ff.dout;
	assign lane_parity_o = s_ff.pout;
	assign data_oe_n_o = s_ff.doe_n;
	assign data_busy_out_n_o = s_ff.busy_n;
	assign data_busy_oe_n_o = s_ff.busy_oe_n;

	// user side outputs, also registered
	assign rdata_o = s_ff.rdata;
	assign rdata_valid_o = s_ff.rvalid;
	assign wdata_req_o = s_ff.wreq;
	assign tenure_done_o = s_ff.done;
	assign tenure_err_o = s_ff.err;
	assign checkstop_o = s_ff.checkstop;
endmodule : pbdt_data_tenure

// ---- common/pbdt_pkg.sv ----
// constants and types for the processor bus data tenure block
package pbdt_pkg;
	localparam int unsigned PBDT_DATA_W = 64;
	localparam int unsigned PBDT_LANES = 8;
	localparam int unsigned PBDT_Q_DEPTH = 4;
	localparam logic [1:0] PBDT_BURST_LAST = 2'h3;
	localparam logic [1:0] PBDT_SINGLE_LAST = 2'h0;
	localparam logic [1:0] PBDT_RETRY_WIN = 2'h2;
	localparam logic [PBDT_DATA_W-1:0] PBDT_DATA_RST = 64'h0000_0000_0000_0000;
	localparam logic [PBDT_LANES-1:0] PBDT_PAR_RST = 8'h00;

	typedef enum logic [1:0] {
		PBDT_IDLE,
		PBDT_XFER,
		PBDT_REL
	} pbdt_state_t;

	typedef struct packed {
		logic write;
		logic burst;
	} pbdt_entry_t;

	typedef struct packed {
		pbdt_state_t st;
		pbdt_entry_t [PBDT_Q_DEPTH-1:0] q;
		logic [PBDT_Q_DEPTH-1:0] qv;
		logic wait_ack;
		logic [1:0] win_cnt;
		logic win_retried;
		logic cur_write;
		logic cur_burst;
		logic [1:0] beat;
		logic [PBDT_DATA_W-1:0] dout;
		logic [PBDT_LANES-1:0] pout;
		logic doe_n;
		logic busy_n;
		logic busy_oe_n;
		logic [PBDT_DATA_W-1:0] rdata;
		logic rvalid;
		logic wreq;
		logic done;
		logic err;
		logic checkstop;
		logic [1:0] sync_ack;
		logic [1:0] sync_tea;
		logic [1:0] sync_dbg;
		logic [1:0] sync_perm;
		logic [1:0] sync_ts;
		logic [1:0] sync_address_ack;
		logic [1:0] sync_rty;
	} pbdt_state_s_t;

	// odd parity bit for one byte
	function automatic logic pbdt_odd_par(input logic [7:0] b);
		return ~(^b);
	endfunction : pbdt_odd_par
endpackage : pbdt_pkg

// ---- bench/pbdt_data_tenure_properties.sv ----
// port checker for the data tenure block
`timescale 1ns/10ps
module pbdt_props
	import pbdt_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic reset_i,
	input wire logic data_grant_in_i,
	input wire logic beat_acknowledge_i,
	input wire logic parity_gen_en_i,
	input wire logic [PBDT_DATA_W-1:0] data_bus_o,
	input wire logic [PBDT_LANES-1:0] lane_parity_o,
	input wire logic data_oe_n_o,
	input wire logic data_busy_out_n_o,
	input wire logic data_busy_oe_n_o,
	input wire logic rdata_valid_o,
	input wire logic wdata_req_o,
	input wire logic tenure_done_o
);
	logic [7:0] h_ff;
	logic [7:0] odd;
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);
	// grant and acknowledge pin history, four edges each, covers the sync delay
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i)
			h_ff <= 8'h00;
		else
			h_ff <= {h_ff[6:4], data_grant_in_i, h_ff[2:0], beat_acknowledge_i};
	end
	// odd parity per lane, lane 0 in the top byte
	always_comb begin
		for (int i = 0; i < 8; i++)
			odd[7-i] = ~^data_bus_o[63-8*i -: 8];
	end
	property p_busy; $fell(data_busy_out_n_o) |-> !data_busy_oe_n_o && |h_ff[7:4]; endproperty
	a_busy: assert property (p_busy) else $error("busy without grant");
	property p_wr; $fell(data_oe_n_o) |-> !data_busy_out_n_o && wdata_req_o; endproperty
	a_wr: assert property (p_wr) else $error("write beat apart from busy");
	property p_par; !data_oe_n_o && parity_gen_en_i |-> lane_parity_o == odd; endproperty
	a_par: assert property (p_par) else $error("lane parity wrong");
	property p_float; tenure_done_o |-> data_oe_n_o; endproperty
	a_float: assert property (p_float) else $error("data still driven");
	property p_rel;
		$rose(data_busy_out_n_o) |-> !data_busy_oe_n_o ##1 data_busy_oe_n_o;
	endproperty
	a_rel: assert property (p_rel) else $error("busy release wrong");
	property p_hold;
		!data_oe_n_o && !$past(data_oe_n_o) && $changed(data_bus_o) |-> |h_ff[3:0];
	endproperty
	a_hold: assert property (p_hold) else $error("beat moved without ack");
	property p_rdv; rdata_valid_o |-> |h_ff[3:0]; endproperty
	a_rdv: assert property (p_rdv) else $error("read beat without ack");
	property p_gap; tenure_done_o |-> data_busy_out_n_o ##1 data_busy_out_n_o; endproperty
	a_gap: assert property (p_gap) else $error("busy too soon");
endmodule : pbdt_props
bind pbdt_data_tenure pbdt_props i_props (.*);

// ---- bench/pbdt_resp.sv ----
// responder model: paced beat acknowledge, read data, write capture
`timescale 1ns/10ps
module pbdt_resp (
	input wire logic clk_i,
	input wire logic busy_n_i,
	input wire logic [63:0] wd_i,
	input wire logic [63:0] rd_i,
	input wire logic [2:0] nbeat_i,
	input wire logic [3:0] wt_i,
	input wire logic bad_i,
	output logic ack_o,
	output logic [63:0] d_o,
	output logic [7:0] p_o,
	output logic [63:0] wcap_o [4]
);
	logic [63:0] v;
	// one pulse per beat once busy is seen, then lines show inverted data
	initial begin
		ack_o = 1'h0;
		d_o = 64'h0000_0000_0000_0000;
		p_o = 8'h00;
		forever begin
			@(posedge clk_i);
			if (busy_n_i === 1'h0) begin
				for (int k = 0; k < nbeat_i; k++) begin
					repeat (3 + wt_i) @(posedge clk_i);
					if (busy_n_i)
						break;
					v = rd_i + 64'(k);
					ack_o <= 1'h1;
					d_o <= v;
					for (int i = 0; i < 8; i++)
						p_o[7-i] <= ~^v[63-8*i -: 8] ^ (i == 7 && bad_i);
					wcap_o[k] <= wd_i;
					@(posedge clk_i);
					ack_o <= 1'h0;
					d_o <= ~v;
					p_o <= ~p_o;
				end
				wait (busy_n_i);
			end
		end
	end
endmodule : pbdt_resp

// ---- bench/pbdt_data_tenure_tb.sv ----
// self-checking bench for the data tenure block
`timescale 1ns/10ps
module pbdt_data_tenure_tb;
	import pbdt_pkg::*;
	logic ref_clk_i = 1'h0, reset_i = 1'h1, data_grant_in_i = 1'h0, transfer_error_ack_i = 1'h0;
	logic write_reorder_permit_i = 1'h0, address_retry_i = 1'h0, transfer_start_i = 1'h0;
	logic address_ack_i = 1'h0, req_valid_i = 1'h0, req_write_i = 1'h0, req_burst_i = 1'h0;
	logic parity_gen_en_i = 1'h1, parity_chk_en_i = 1'h1, bad = 1'h0;
	logic beat_acknowledge_i, data_oe_n_o, data_busy_out_n_o, data_busy_oe_n_o, rdata_valid_o;
	logic wdata_req_o, tenure_done_o, tenure_err_o, checkstop_o;
	logic [63:0] wdata_i = 64'h0123_4567_89ab_cdef, rd = 64'h0fed_cba9_8765_4321, w0;
	logic [63:0] data_bus_i, data_bus_o, rdata_o;
	logic [63:0] wcap [4];
	logic [63:0] rq [$];
	logic [7:0] lane_parity_i, lane_parity_o;
	logic [2:0] nb = 3'h1;
	logic [3:0] wt = 4'h0;
	int fails = 0, comparisons = 0, cyc = 0;
	pbdt_data_tenure i_dut (.*);
	pbdt_resp i_resp (.clk_i(ref_clk_i), .busy_n_i(data_busy_out_n_o), .wd_i(data_bus_o),
		.rd_i(rd), .nbeat_i(nb), .wt_i(wt), .bad_i(bad), .ack_o(beat_acknowledge_i),
		.d_o(data_bus_i), .p_o(lane_parity_i), .wcap_o(wcap));
	initial begin
		forever #20 ref_clk_i = ~ref_clk_i;
	end
	// next write beat, read beat capture, hang guard
	always @(posedge ref_clk_i) begin
		if (wdata_req_o === 1'h1)
			wdata_i <= wdata_i + 64'h0000_0000_0000_0001;
		if (rdata_valid_o === 1'h1)
			rq.push_back(rdata_o);
		cyc++;
		if (cyc == 4000) begin
			fails++;
			give_verdict();
		end
	end
	task automatic chk(input string n, input logic [63:0] g, input logic [63:0] e);
		comparisons++;
		if (g !== e) begin
			fails++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : give_verdict
	task automatic issue(input logic w, input logic b);
		{req_valid_i, req_write_i, req_burst_i, transfer_start_i} <= {1'h1, w, b, 1'h1};
		@(posedge ref_clk_i);
		transfer_start_i <= 1'h0;
		repeat (3) @(posedge ref_clk_i);
		{req_valid_i, address_ack_i} <= 2'h1;
		@(posedge ref_clk_i);
		address_ack_i <= 1'h0;
		repeat (4) @(posedge ref_clk_i);
	endtask : issue
	task automatic run(input logic w, input int n, input logic e);
		int t;
		nb <= 3'(n);
		data_grant_in_i <= 1'h1;
		for (t = 0; t < 40 && data_busy_out_n_o !== 1'h0; t++)
			@(posedge ref_clk_i);
		data_grant_in_i <= 1'h0;
		chk("busy", 64'(data_busy_out_n_o), 64'h0);
		chk("drive", 64'(data_oe_n_o), 64'(!w));
		transfer_error_ack_i <= e;
		@(posedge ref_clk_i);
		transfer_error_ack_i <= 1'h0;
		for (t = 0; t < 200 && tenure_done_o !== 1'h1 && tenure_err_o !== 1'h1; t++)
			@(posedge ref_clk_i);
		chk("end", 64'(t < 200), 64'h1);
		chk("err", 64'(tenure_err_o), 64'(e));
		repeat (3) @(posedge ref_clk_i);
		chk("busy_oe", 64'(data_busy_oe_n_o), 64'h1);
	endtask : run
	task automatic xfer(input logic w, input int n, input logic e);
		w0 = wdata_i;
		rd = rd + 64'h0000_0000_0001_0000;
		rq.delete();
		issue(w, n > 1);
		run(w, n, e);
		for (int k = 0; k < n && !e; k++)
			chk("beat", w ? wcap[k] : rq[k], (w ? w0 : rd) + 64'(k));
		if (!w && !e)
			chk("reads", 64'(rq.size()), 64'(n));
		$display("test %0d-beat %s done", n, w ? "write" : "read");
	endtask : xfer
	task automatic t_hold();
		data_grant_in_i <= 1'h1;
		repeat (12) @(posedge ref_clk_i);
		chk("idle_grant", 64'(data_busy_out_n_o), 64'h1);
		data_grant_in_i <= 1'h0;
		issue(1'h0, 1'h0);
		repeat (12) @(posedge ref_clk_i);
		chk("no_grant", 64'(data_busy_out_n_o), 64'h1);
		run(1'h0, 1, 1'h0);
		$display("test grant hold done");
	endtask : t_hold
	task automatic t_order();
		for (int p = 0; p < 2; p++) begin
			write_reorder_permit_i <= p[0];
			issue(1'h0, 1'h0);
			issue(1'h1, 1'h0);
			run(p[0], 1, 1'h0);
			write_reorder_permit_i <= 1'h0;
			run(!p[0], 1, 1'h0);
		end
		$display("test order done");
	endtask : t_order
	initial begin
		repeat (3) @(posedge ref_clk_i);
		reset_i <= 1'h0;
		repeat (3) @(posedge ref_clk_i);
		chk("oe_rst", 64'(data_oe_n_o), 64'h1);
		xfer(1'h1, 1, 1'h0);
		wt <= 4'h4;
		xfer(1'h1, 4, 1'h0);
		write_reorder_permit_i <= 1'h1;
		xfer(1'h0, 4, 1'h0);
		t_hold();
		t_order();
		xfer(1'h0, 4, 1'h1);
		chk("no_stop", 64'(checkstop_o), 64'h0);
		bad <= 1'h1;
		xfer(1'h0, 1, 1'h0);
		chk("stop", 64'(checkstop_o), 64'h1);
		give_verdict();
	end
endmodule : pbdt_data_tenure_tb
